// File: src/qcc_top.sv
// Quad comparator control: registers, comparator clocking, flags, capture
// Summary of operation
// - Result bit is high when positive input exceeds selected negative input.
// - A new result is sampled each comparator clock, I/O clock or half.
// - Each of the four comparators has its own interrupt request.
// - Sensitivity 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// - Control bit 7 switches the comparator on, zero switches it off.
// - Control bit 6 gates the comparator interrupt request to the processor.
// - Negative select: 000-011 references, 100 bandgap, 101 DAC, 110 pin.
// - Comparator 0 control bit 3 picks PLL clock, else the I/O clock.
// - Comparator 1 bit 3 routes its output into the timer capture input.
// - Routed capture uses rising edge when edge select is one, else falling.
// - Capture interrupt from a comparator needs the timer capture mask set.
// - With routing off the comparator is disconnected from timer capture.
// - Each interrupt flag is offered as ADC and DAC start trigger.
// - Amplifier connect feeds positive input and clock from that amplifier.
// - Control registers of comparators 0 to 3 reset to zero.
// - Flag is set when the output gives the selected sensitivity event.
// - Flag clears on vector execution with interrupt enabled, or write one.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "qcc_defs.svh"

module qcc_top (
  // Clock, reset, clock enable
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  input  wire logic                           ce,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [`QCC_ADDR_W-1:0]         paddr,
  input  wire logic [`QCC_DATA_W-1:0]         pwdata,
  output logic      [`QCC_DATA_W-1:0]         prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Analog comparator cores
  input  wire logic [`QCC_NCMP-1:0]           cmp_raw,
  input  wire logic                           pll_clk,
  input  wire logic [`QCC_NAMP-1:0]           amp_clk,
  output qcc_pkg::qcc_ctrl_t [`QCC_NCMP-1:0]  cmp_ctrl,
  output logic      [`QCC_NAMP-1:0]           amplifier_connect,
  output logic      [`QCC_NCMP-1:0]           cmp_sample,
  output logic      [`QCC_NCMP-1:0]           cmp_result,
  // Timer capture front end
  input  wire logic                           capture_edge_select,
  input  wire logic                           capture_irq_mask,
  output logic                                capture_in,
  output logic                                capture_event,
  output logic                                capture_irq,
  // Interrupt controller and converter triggers
  input  wire logic [`QCC_NCMP-1:0]           irq_ack,
  output logic      [`QCC_NCMP-1:0]           cmp_irq,
  output logic      [`QCC_NCMP-1:0]           cmp_irq_flag,
  output logic                                irq
);

  qcc_pkg::qcc_ctrl_t [`QCC_NCMP-1:0] ctrl_ff;
  qcc_pkg::qcc_ctrl_t [`QCC_NCMP-1:0] nxt_ctrl;
  qcc_pkg::qcc_evt_t  [`QCC_NCMP-1:0] evt;
  logic [`QCC_NAMP:0]                 aux_ff;
  logic [`QCC_NAMP:0]                 nxt_aux;
  logic [`QCC_NCMP-1:0]               flag_ff;
  logic [`QCC_NCMP-1:0]               nxt_flag;
  logic [`QCC_NCMP-1:0]               mask_ff;
  logic [`QCC_NCMP-1:0]               nxt_mask;
  logic [`QCC_NCMP-1:0]               flag_clr;
  logic [`QCC_NCMP-1:0]               hit;
  logic [`QCC_NCMP-1:0]               ie_vec;
  logic [`QCC_NCMP-1:0]               sample_vec;
  logic [`QCC_NCMP-1:0]               sample_ff;
  logic [`QCC_NCMP-1:0]               result_ff;
  logic [`QCC_NAMP-1:0]               amp_conn;
  logic [2:0]                         pll_sync_ff;
  logic [2:0]                         amp_sync_ff [`QCC_NAMP];
  logic [`QCC_NAMP-1:0]               amp_tick;
  logic                               pll_tick;
  logic                               half_ff;
  logic                               io_tick;
  logic                               base_tick;
  logic                               wr_en;
  logic                               rd_setup;
  logic [`QCC_DATA_W-1:0]             nxt_rdata;
  logic                               nxt_err;
  logic [`QCC_DATA_W-1:0]             prdata_ff;
  logic                               pready_ff;
  logic                               pslverr_ff;
  logic                               cap_in_ff;
  logic                               cap_evt_ff;
  logic                               cap_irq_ff;
  logic [`QCC_NCMP-1:0]               irq_req_ff;
  logic                               irq_ff;

  // Writes a control byte, keeping bit 3 zero where it has no meaning
  function automatic qcc_pkg::qcc_ctrl_t ctrl_load(
    input logic [7:0] wdata,
    input logic [7:0] keep);
    return qcc_pkg::qcc_ctrl_t'(wdata & keep);
  endfunction

  function automatic logic addr_is(input logic [`QCC_ADDR_W-1:0] a,
                                   input logic [7:0] idx);
    return a == `QCC_ADDR(idx);
  endfunction

  // ---------------- APB ----------------
  // Zero wait states: the access phase always completes at its first edge
  assign rd_setup = psel & ~penable;
  assign wr_en    = psel & penable & pready_ff & pwrite;

  always_comb
  begin
    nxt_rdata = `QCC_ZERO_WORD;
    nxt_err   = 1'b0;
    if (addr_is(paddr, `QCC_IDX_CTRL0))
      nxt_rdata[7:0] = ctrl_ff[0];
    else if (addr_is(paddr, `QCC_IDX_CTRL1))
      nxt_rdata[7:0] = ctrl_ff[1];
    else if (addr_is(paddr, `QCC_IDX_CTRL2))
      nxt_rdata[7:0] = ctrl_ff[2];
    else if (addr_is(paddr, `QCC_IDX_CTRL3))
      nxt_rdata[7:0] = ctrl_ff[3];
    else if (addr_is(paddr, `QCC_IDX_AUX))
      nxt_rdata[`QCC_NAMP:0] = aux_ff;
    else if (addr_is(paddr, `QCC_IDX_STATUS))
      nxt_rdata[7:0] = {result_ff, flag_ff};
    else if (addr_is(paddr, `QCC_IDX_MASK))
      nxt_rdata[`QCC_NCMP-1:0] = mask_ff;
    else
      nxt_err = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      prdata_ff  <= `QCC_ZERO_WORD;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else if (ce)
    begin
      pready_ff  <= rd_setup;
      pslverr_ff <= rd_setup & nxt_err;
      if (rd_setup && !pwrite)
        prdata_ff <= nxt_rdata;
    end
  end

  // ---------------- Control registers ----------------
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_aux  = aux_ff;
    nxt_mask = mask_ff;
    if (wr_en)
    begin
      if (addr_is(paddr, `QCC_IDX_CTRL0))
        nxt_ctrl[0] = ctrl_load(pwdata[7:0], `QCC_CTRL_MASK_B3);
      if (addr_is(paddr, `QCC_IDX_CTRL1))
        nxt_ctrl[1] = ctrl_load(pwdata[7:0], `QCC_CTRL_MASK_B3);
      if (addr_is(paddr, `QCC_IDX_CTRL2))
        nxt_ctrl[2] = ctrl_load(pwdata[7:0], `QCC_CTRL_MASK_NB3);
      if (addr_is(paddr, `QCC_IDX_CTRL3))
        nxt_ctrl[3] = ctrl_load(pwdata[7:0], `QCC_CTRL_MASK_NB3);
      if (addr_is(paddr, `QCC_IDX_AUX))
        nxt_aux = pwdata[`QCC_NAMP:0];
      if (addr_is(paddr, `QCC_IDX_MASK))
        nxt_mask = pwdata[`QCC_NCMP-1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `QCC_NCMP; i++)
        ctrl_ff[i] <= qcc_pkg::qcc_ctrl_t'(`QCC_CTRL_RESET);
      aux_ff  <= `QCC_AUX_RESET;
      mask_ff <= `QCC_FLAG_RESET;
    end
    else if (ce)
    begin
      ctrl_ff <= nxt_ctrl;
      aux_ff  <= nxt_aux;
      mask_ff <= nxt_mask;
    end
  end

  assign amp_conn = aux_ff[`QCC_AUX_AMP_LSB +: `QCC_NAMP];

  // ---------------- Comparator clocking ----------------
  // PLL and amplifier clocks come from other domains; their falling edges
  // are seen through a three-stage chain, the first stage unread elsewhere
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pll_sync_ff <= `QCC_SYNC_RESET;
      for (int i = 0; i < `QCC_NAMP; i++)
        amp_sync_ff[i] <= `QCC_SYNC_RESET;
    end
    else if (ce)
    begin
      pll_sync_ff <= {pll_sync_ff[1:0], pll_clk};
      for (int i = 0; i < `QCC_NAMP; i++)
        amp_sync_ff[i] <= {amp_sync_ff[i][1:0], amp_clk[i]};
    end
  end

  assign pll_tick = pll_sync_ff[2] & ~pll_sync_ff[1];

  always_comb
  begin
    for (int i = 0; i < `QCC_NAMP; i++)
      amp_tick[i] = amp_sync_ff[i][2] & ~amp_sync_ff[i][1];
  end

  // I/O clock halving alternates the comparison strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      half_ff <= 1'b0;
    else if (ce)
      half_ff <= ~half_ff;
  end

  assign io_tick   = aux_ff[`QCC_AUX_HALVE] ? half_ff : 1'b1;
  assign base_tick = ctrl_ff[0].ctrl_bit3 ? pll_tick : io_tick;

  always_comb
  begin
    sample_vec = {`QCC_NCMP{base_tick}};
    for (int i = 0; i < `QCC_NAMP; i++)
      if (amp_conn[i])
        sample_vec[i] = amp_tick[i];
  end

  // ---------------- Per comparator sampling and events ----------------
  for (genvar g = 0; g < `QCC_NCMP; g++)
  begin : g_cmp
    qcc_event u_event (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .ce      (ce),
      .sample  (sample_vec[g]),
      .ctrl    (ctrl_ff[g]),
      .cmp_raw (cmp_raw[g]),
      .evt     (evt[g])
    );
    assign hit[g]       = evt[g].event_hit;
    assign result_ff[g] = evt[g].cmp_result;
    assign ie_vec[g]    = nxt_ctrl[g].cmp_irq_enable;
  end

  // ---------------- Flags and interrupts ----------------
  // Clears come from software ones or from a serviced vector
  always_comb
  begin
    flag_clr = irq_ack & {ctrl_ff[3].cmp_irq_enable,
                          ctrl_ff[2].cmp_irq_enable,
                          ctrl_ff[1].cmp_irq_enable,
                          ctrl_ff[0].cmp_irq_enable};
    if (wr_en && addr_is(paddr, `QCC_IDX_STATUS))
      flag_clr = flag_clr | pwdata[`QCC_NCMP-1:0];
    // A new event in the clearing cycle wins
    nxt_flag = (flag_ff & ~flag_clr) | hit;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      flag_ff    <= `QCC_FLAG_RESET;
      irq_req_ff <= `QCC_FLAG_RESET;
      irq_ff     <= 1'b0;
    end
    else if (ce)
    begin
      flag_ff    <= nxt_flag;
      irq_req_ff <= nxt_flag & ie_vec;
      irq_ff     <= |(nxt_flag & nxt_mask);
    end
  end

  // ---------------- Timer capture routing ----------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cap_in_ff  <= 1'b0;
      cap_evt_ff <= 1'b0;
      cap_irq_ff <= 1'b0;
      sample_ff  <= `QCC_FLAG_RESET;
    end
    else if (ce)
    begin
      sample_ff  <= sample_vec;
      // Route off holds the capture input low, so no edge reaches it
      cap_in_ff  <= ctrl_ff[1].ctrl_bit3 & evt[1].cmp_result;
      cap_evt_ff <= ctrl_ff[1].ctrl_bit3 &
                    (capture_edge_select ? evt[1].rise
                                         : evt[1].fall);
      cap_irq_ff <= ctrl_ff[1].ctrl_bit3 & capture_irq_mask &
                    (capture_edge_select ? evt[1].rise
                                         : evt[1].fall);
    end
  end

  // ---------------- Outputs ----------------
  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign cmp_ctrl          = ctrl_ff;
  assign amplifier_connect = amp_conn;
  assign cmp_sample        = sample_ff;
  assign cmp_result        = result_ff;
  assign capture_in        = cap_in_ff;
  assign capture_event     = cap_evt_ff;
  assign capture_irq       = cap_irq_ff;
  assign cmp_irq           = irq_req_ff;
  assign cmp_irq_flag      = flag_ff;
  assign irq               = irq_ff;

endmodule

// File: src/qcc_defs.svh
// Register map, field positions and reset values of the comparator control
`ifndef QCC_DEFS_SVH
`define QCC_DEFS_SVH

// Printed register indices; the APB byte address is four times the index
`define QCC_IDX_CTRL0     8'h94
`define QCC_IDX_CTRL1     8'h95
`define QCC_IDX_CTRL2     8'h96
`define QCC_IDX_CTRL3     8'h97
`define QCC_IDX_AUX       8'h98
`define QCC_IDX_STATUS    8'h99
`define QCC_IDX_MASK      8'h9a
`define QCC_ADDR(idx)     ({2'b00, (idx), 2'b00})

`define QCC_ADDR_W        12
`define QCC_DATA_W        32
`define QCC_NCMP          4
`define QCC_NAMP          3

// Control register fields
`define QCC_CTRL_RESET    8'h00
`define QCC_CTRL_BIT3     3
`define QCC_CTRL_MASK_B3  8'hff
`define QCC_CTRL_MASK_NB3 8'hf7

// Own auxiliary register: clock halving and amplifier connection
`define QCC_AUX_HALVE     0
`define QCC_AUX_AMP_LSB   1
`define QCC_AUX_RESET     4'h0

// Status: flags in [3:0] (write one to clear), results in [7:4]
`define QCC_STAT_RES_LSB  4
`define QCC_FLAG_RESET    4'h0

`define QCC_SYNC_RESET    3'h0
`define QCC_ZERO_WORD     32'h0000_0000

`endif

// File: src/qcc_pkg.sv
// Types shared by the comparator control block
package qcc_pkg;

  typedef enum logic [1:0] {
    QCC_SENS_TOGGLE = 2'b00,
    QCC_SENS_RSVD   = 2'b01,
    QCC_SENS_FALL   = 2'b10,
    QCC_SENS_RISE   = 2'b11
  } qcc_sens_t;

  typedef enum logic [2:0] {
    QCC_NEG_REF0    = 3'b000,
    QCC_NEG_REF1    = 3'b001,
    QCC_NEG_REF2    = 3'b010,
    QCC_NEG_REF3    = 3'b011,
    QCC_NEG_BANDGAP = 3'b100,
    QCC_NEG_DAC     = 3'b101,
    QCC_NEG_EXT_PIN = 3'b110,
    QCC_NEG_RSVD    = 3'b111
  } qcc_neg_t;

  // One comparator control byte as software sees it
  typedef struct packed {
    logic      cmp_enable;
    logic      cmp_irq_enable;
    qcc_sens_t irq_sensitivity;
    logic      ctrl_bit3;
    qcc_neg_t  neg_input_select;
  } qcc_ctrl_t;

  // Result and edge pulses of one comparator
  typedef struct packed {
    logic cmp_result;
    logic rise;
    logic fall;
    logic event_hit;
  } qcc_evt_t;

endpackage

// File: src/qcc_event.sv
// One comparator: pin synchroniser, clocked result sampling, event decode
`timescale 1ns/1ns
`include "qcc_defs.svh"

module qcc_event (
  // Clock, reset, enable
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  // Control
  input  wire logic               sample,
  input  wire qcc_pkg::qcc_ctrl_t ctrl,
  // Raw comparator output from the analog core
  input  wire logic               cmp_raw,
  // Sampled result and pulses
  output qcc_pkg::qcc_evt_t       evt
);

  logic              sync1_ff;
  logic              sync2_ff;
  logic              res_ff;
  logic              rise_ff;
  logic              fall_ff;
  logic              hit_ff;
  logic              nxt_res;

  function automatic logic sens_hit(input qcc_pkg::qcc_sens_t s,
                                    input logic now_v,
                                    input logic old_v);
    logic r;
    r = 1'b0;
    unique case (s)
      qcc_pkg::QCC_SENS_TOGGLE: r = now_v ^ old_v;
      qcc_pkg::QCC_SENS_RSVD:   r = 1'b0;
      qcc_pkg::QCC_SENS_FALL:   r = old_v & ~now_v;
      qcc_pkg::QCC_SENS_RISE:   r = now_v & ~old_v;
    endcase
    return r;
  endfunction

  // Raw output is asynchronous to mclk
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else if (ce)
    begin
      sync1_ff <= cmp_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // A disabled comparator reads low
  assign nxt_res = ctrl.cmp_enable & sync2_ff;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      res_ff  <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
      hit_ff  <= 1'b0;
    end
    else if (ce)
    begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
      hit_ff  <= 1'b0;
      if (sample)
      begin
        res_ff  <= nxt_res;
        rise_ff <= nxt_res & ~res_ff;
        fall_ff <= res_ff & ~nxt_res;
        // Disabling pulls the result low; that fall is no event
        hit_ff  <= ctrl.cmp_enable &
                   sens_hit(ctrl.irq_sensitivity, nxt_res, res_ff);
      end
      // A slow strobe must not leave a stale high on a disabled core
      else if (!ctrl.cmp_enable)
        res_ff  <= 1'b0;
    end
  end

  assign evt = '{cmp_result: res_ff, rise: rise_ff, fall: fall_ff,
                 event_hit: hit_ff};

endmodule

// File: sim/qcc_assertions.sv
// Port-level checker of the quad comparator control block
`timescale 1ns/1ns

module qcc_checker (
  // Clock and reset
  input wire logic                     mclk,
  input wire logic                     rst_n,
  // APB
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic                     pready,
  // Comparators
  input wire qcc_pkg::qcc_ctrl_t [3:0] cmp_ctrl,
  input wire logic [3:0]               cmp_result,
  // Timer capture
  input wire logic                     capture_edge_select,
  input wire logic                     capture_irq_mask,
  input wire logic                     capture_in,
  input wire logic                     capture_event,
  input wire logic                     capture_irq,
  // Interrupts
  input wire logic [3:0]               irq_ack,
  input wire logic [3:0]               cmp_irq,
  input wire logic [3:0]               cmp_irq_flag
);
  logic [3:0] prev_res_ff;
  logic [3:0] chg;
  logic [3:0] ie;
  logic [3:0] en;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge mclk)
    prev_res_ff <= cmp_result;

  // A result change seen now may still set its flag at the coming edge
  assign chg = cmp_result ^ prev_res_ff;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      ie[i] = cmp_ctrl[i].cmp_irq_enable;
      en[i] = cmp_ctrl[i].cmp_enable;
    end
  end

  a_irq_gated: assert property (cmp_irq == (cmp_irq_flag & ie))
    else $error("comparator request is not flag and enable");
  a_off_quiet: assert property
    (((~en) & $past(~en) & cmp_result) == 4'h0)
    else $error("disabled comparator shows a result");
  a_flag_cause: assert property
    ((cmp_irq_flag & ~$past(cmp_irq_flag) & ~$past(chg)) == 4'h0)
    else $error("flag set without a result change");
  a_flag_off: assert property ($rose(cmp_irq_flag[0]) |->
    $past(en[0], 2) &&
    $past(cmp_ctrl[0].irq_sensitivity, 2) != qcc_pkg::QCC_SENS_RSVD)
    else $error("flag set while off or reserved");
  a_rise_sel: assert property ($rose(cmp_irq_flag[0]) &&
    $past(cmp_ctrl[0].irq_sensitivity, 2) == qcc_pkg::QCC_SENS_RISE
    |-> $past(cmp_result[0]))
    else $error("rising selection flagged a fall");
  a_fall_sel: assert property ($rose(cmp_irq_flag[0]) &&
    $past(cmp_ctrl[0].irq_sensitivity, 2) == qcc_pkg::QCC_SENS_FALL
    |-> !$past(cmp_result[0]))
    else $error("falling selection flagged a rise");
  a_capture_off: assert property (!cmp_ctrl[1].ctrl_bit3 [*2]
    |-> !capture_in && !capture_event && !capture_irq)
    else $error("capture active while not routed");
  a_cap_edge: assert property (capture_event |->
    $past(cmp_result[1]) == $past(capture_edge_select))
    else $error("capture on the wrong edge");
  a_cap_mask: assert property (capture_irq |->
    capture_event && $past(capture_irq_mask))
    else $error("capture interrupt without event and mask");
  a_vec_clear: assert property (irq_ack[0] && ie[0] && !chg[0]
    |=> !cmp_irq_flag[0])
    else $error("vector did not clear the flag");
  a_flag_hold: assert property ($fell(cmp_irq_flag[0]) |->
    $past(irq_ack[0]) || $past(psel && pwrite && penable))
    else $error("flag dropped without a clear");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");

  cover property ($rose(cmp_irq_flag[0]));
  cover property (capture_event && capture_irq);
  cover property (irq_ack[0] && cmp_irq_flag[0]);
endmodule

bind qcc_top qcc_checker u_chk (.*);

// File: sim/qcc_analog_model.sv
// Behavioural model of the four comparator cores and their clocks
`timescale 1ns/1ns

module qcc_analog_model #(
  parameter logic [7:0] DAC_LVL = 8'h60,
  parameter logic [7:0] PIN_LVL = 8'h70
) (
  // Clock and settings from the block
  input  wire logic                     mclk,
  input  wire qcc_pkg::qcc_ctrl_t [3:0] cmp_ctrl,
  // Positive input levels set by the bench
  input  wire logic [3:0][7:0]          pos_lvl,
  // Outputs and clocks towards the block
  output logic [3:0]                    cmp_raw,
  output logic                          pll_clk,
  output logic [2:0]                    amp_clk
);
  logic [7:0] neg;
  logic       junk_ff = 1'b0;

  // Unrelated in phase to mclk
  initial pll_clk = 1'b0;
  always #37 pll_clk = ~pll_clk;
  initial amp_clk = 3'h0;
  always #61 amp_clk = ~amp_clk;

  // A powered-down core gives garbage, so the block has to mask it
  always @(posedge mclk)
    junk_ff <= ~junk_ff;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      case (cmp_ctrl[i].neg_input_select)
        qcc_pkg::QCC_NEG_BANDGAP: neg = 8'h50;
        qcc_pkg::QCC_NEG_DAC:     neg = DAC_LVL;
        qcc_pkg::QCC_NEG_EXT_PIN: neg = PIN_LVL;
        qcc_pkg::QCC_NEG_RSVD:    neg = 8'hff;
        default: neg = {1'b0, 3'(cmp_ctrl[i].neg_input_select) + 3'h1, 4'h0};
      endcase
      if (!cmp_ctrl[i].cmp_enable)
        cmp_raw[i] = junk_ff ^ i[0];
      else
        cmp_raw[i] = pos_lvl[i] > neg;
    end
  end
endmodule

// File: sim/qcc_top_tb.sv
// Self-checking bench of the quad comparator control block
`timescale 1ns/1ns
`include "qcc_defs.svh"

module qcc_top_tb;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
    logic        err;
  } qcc_row_t;

  localparam logic [11:0] C0 = `QCC_ADDR(`QCC_IDX_CTRL0);
  localparam logic [11:0] C1 = `QCC_ADDR(`QCC_IDX_CTRL1);
  localparam logic [11:0] C2 = `QCC_ADDR(`QCC_IDX_CTRL2);
  localparam logic [11:0] C3 = `QCC_ADDR(`QCC_IDX_CTRL3);
  localparam logic [11:0] AUX = `QCC_ADDR(`QCC_IDX_AUX);
  localparam logic [11:0] ST = `QCC_ADDR(`QCC_IDX_STATUS);
  localparam logic [11:0] MSK = `QCC_ADDR(`QCC_IDX_MASK);

  logic               mclk = 1'b0;
  logic               rst_n = 1'b0;
  logic               ce = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic [31:0]        rd_val;
  logic               pready;
  logic               pslverr;
  logic               rd_err;
  logic [3:0]         cmp_raw;
  logic               pll_clk;
  logic [2:0]         amp_clk;
  logic [3:0]         cmp_result;
  logic [3:0]         cmp_irq;
  logic [3:0]         cmp_irq_flag;
  logic [3:0]         irq_ack = 4'h0;
  logic [2:0]         amplifier_connect;
  logic               capture_edge_select = 1'b0;
  logic               capture_irq_mask = 1'b0;
  logic               capture_in;
  logic               capture_event;
  logic               capture_irq;
  logic               irq;
  logic [3:0][7:0]    pos_lvl = 32'h0;
  qcc_pkg::qcc_ctrl_t [3:0] cmp_ctrl;
  int                 miscompares = 0;
  int                 num_checks = 0;
  int                 n_evt = 0;
  int                 n_cirq = 0;
  logic [3:0]         cmp_sample;
  logic               s_prev;
  qcc_row_t           rows [7] = '{
    '{C0, 8'hff, 8'hff, 1'b0}, '{C1, 8'hff, 8'hff, 1'b0},
    '{C2, 8'hff, 8'hf7, 1'b0}, '{C3, 8'hff, 8'hf7, 1'b0},
    '{AUX, 8'h0f, 8'h0f, 1'b0}, '{MSK, 8'h0f, 8'h0f, 1'b0},
    '{12'h300, 8'hff, 8'h00, 1'b1}};

  always #25 mclk = ~mclk;

  // Capture pulses stand one cycle; count them where they are settled
  always @(negedge mclk)
  begin
    n_evt += capture_event;
    n_cirq += capture_irq;
  end

  qcc_top u_dut (.*);
  qcc_analog_model u_amod (.mclk, .cmp_ctrl, .pos_lvl, .cmp_raw, .pll_clk,
                           .amp_clk);

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Waits for ready with no assumed latency; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(negedge mclk);
    while (pready !== 1'b1)
      @(negedge mclk);
    rd_val = prdata;
    rd_err = pslverr;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic check_reset;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, C0 + 12'(4 * i), 8'h00);
      chk("reset value", rd_val, 32'h0);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    check_reset();
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 8'h00);
      chk("readback", rd_val, {24'h0, rows[i].e});
      chk("slave error", rd_err, rows[i].err);
      apb(1'b1, rows[i].a, 8'h00);
    end
    apb(1'b1, AUX, 8'h0e);
    cyc(1);
    chk("amp connect", amplifier_connect, 3'h7);
    apb(1'b1, AUX, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, C0, {2'b11, 2'(s), 4'h6});
      cyc(8);
      apb(1'b1, ST, 8'h0f);
      pos_lvl[0] <= 8'h80;
      cyc(8);
      chk("rise flag", cmp_irq_flag[0], s == 0 || s == 3);
      apb(1'b1, ST, 8'h0f);
      pos_lvl[0] <= 8'h00;
      cyc(8);
      chk("fall flag", cmp_irq_flag[0], s == 0 || s == 2);
    end
    apb(1'b1, MSK, 8'h01);
    pos_lvl[0] <= 8'h80;
    cyc(8);
    chk("irq line", irq, 1'b1);
    chk("cmp irq", cmp_irq[0], 1'b1);
    chk("adc trigger", cmp_irq_flag[0], 1'b1);
    apb(1'b1, MSK, 8'h00);
    cyc(1);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, ST, 8'h01);
    cyc(1);
    chk("flag w1c", cmp_irq_flag[0], 1'b0);
    pos_lvl[0] <= 8'h00;
    cyc(8);
    pos_lvl[0] <= 8'h80;
    cyc(8);
    irq_ack <= 4'h1;
    @(posedge mclk);
    irq_ack <= 4'h0;
    cyc(1);
    chk("vector clear", cmp_irq_flag[0], 1'b0);
    // Halved clock, PLL clock, amplifier clock in turn
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, AUX, {6'h00, k == 2, k == 0});
      apb(1'b1, C0, {4'hf, k == 1, 3'h6});
      pos_lvl[0] <= 8'h00;
      cyc(10);
      apb(1'b1, ST, 8'h0f);
      pos_lvl[0] <= 8'h80;
      for (int n = 0; n < 40 && cmp_irq_flag[0] !== 1'b1; n++)
        @(posedge mclk);
      chk("clocked flag", cmp_irq_flag[0], 1'b1);
      @(negedge mclk);
      s_prev = cmp_sample[0];
      @(negedge mclk);
      if (k == 0)
        chk("halved strobe", cmp_sample[0], !s_prev);
    end
    apb(1'b1, AUX, 8'h00);
    pos_lvl[2] <= 8'h55;
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, C2, {5'h10, 3'(c)});
      cyc(8);
      apb(1'b0, ST, 8'h00);
      chk("result bit", rd_val[6], c < 5);
    end
    apb(1'b1, C3, 8'h00);
    cyc(20);
    chk("off result", cmp_result[3], 1'b0);
    chk("off flag", cmp_irq_flag[3], 1'b0);
    apb(1'b1, C3, 8'h96);
    pos_lvl[3] <= 8'h80;
    cyc(10);
    chk("reserved flag", cmp_irq_flag[3], 1'b0);
    chk("on result", cmp_result[3], 1'b1);
    capture_edge_select <= 1'b1;
    capture_irq_mask <= 1'b1;
    apb(1'b1, C1, 8'hbe);
    // Let the start-up noise of the freshly enabled core pass
    cyc(8);
    n_evt = 0;
    n_cirq = 0;
    pos_lvl[1] <= 8'h80;
    cyc(8);
    chk("capture in", capture_in, 1'b1);
    capture_edge_select <= 1'b0;
    capture_irq_mask <= 1'b0;
    pos_lvl[1] <= 8'h00;
    cyc(8);
    chk("capture low", capture_in, 1'b0);
    apb(1'b1, C1, 8'hb6);
    pos_lvl[1] <= 8'h80;
    cyc(8);
    chk("capture cut", capture_in, 1'b0);
    chk("capture events", n_evt, 32'd2);
    chk("capture irqs", n_cirq, 32'd1);
    rst_n <= 1'b0;
    cyc(6);
    rst_n <= 1'b1;
    check_reset();
    tally_and_finish();
  end

  initial
  begin
    #(50 * 20000);
    miscompares++;
    tally_and_finish();
  end
endmodule
